// file: dv/ext_reset_chip.sv
// Purpose: Outside chip sharing the open-drain reset line with the device.
// Assumes: The line has a pull-up, so it reads high when nobody pulls it.
// Notes: pull_low is commanded by the bench to request a pin reset.
`timescale 1ns/100ps

module ext_reset_chip
(
	input wire logic ref_clk,
	input wire logic dut_oe_n,
	input wire logic pull_low,
	output logic pin_level,
	output int resets_seen
);
	logic last_q = 1'b1;

	// Either party pulling low wins over the pull-up.
	assign pin_level = ~(~dut_oe_n | pull_low);

	// Each new pull by the device resets this chip once.
	initial resets_seen = 0;
	always @(posedge ref_clk)
	begin
		if (last_q && dut_oe_n === 1'b0)
			resets_seen <= resets_seen + 1;
		last_q <= dut_oe_n;
	end
endmodule

// file: dv/test_reset_source_sequencer.sv
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: A watchdog width of 2, so overflow comes after four prescaler wraps.
// Notes: Stop recovery is run in both its short and its long form.
`timescale 1ns/100ps

module test_reset_source_sequencer
	import reset_seq_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, reset_pin_out, reset_pin_oe_n, pin_level, pull_low = 1'b0;
	logic power_on_pulse = 1'b0, brownout_trip = 1'b0, wake_event = 1'b0;
	logic cpu_illegal_opcode = 1'b0, cpu_stop_instr = 1'b0;
	logic cpu_opcode_fetch = 1'b0, cpu_addr_unmapped = 1'b0;
	logic break_active = 1'b0, monitor_mode = 1'b0;
	logic internal_reset, vector_fetch, osc_enable, cpu_clock_enable;
	logic bus_clock_en, gpio_pin_level;
	logic [31:0] rd;
	int error_cnt = 0, checks = 0, cyc_cnt = 0, vf_cnt = 0;
	int resets_seen, drive, total, n;
	int flag[3] = '{FLAG_BAD_OPCODE, FLAG_BAD_OPCODE, FLAG_BAD_ADDRESS};

	// Clock of 8 ns.
	always #4 ref_clk = ~ref_clk;

	reset_source_sequencer #(.WDOG_WIDTH(2)) u_dut
	(
		.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .power_on_pulse, .brownout_trip,
		.reset_pin_in(pin_level), .reset_pin_out, .reset_pin_oe_n,
		.cpu_illegal_opcode, .cpu_stop_instr, .cpu_opcode_fetch, .cpu_addr_unmapped,
		.break_active, .monitor_mode, .wake_event, .internal_reset, .vector_fetch,
		.osc_enable, .cpu_clock_enable, .bus_clock_en, .gpio_pin_level
	);

	ext_reset_chip u_ext
	(
		.ref_clk, .dut_oe_n(reset_pin_oe_n), .pull_low, .pin_level, .resets_seen
	);

	// Counts vector fetches and cuts a hang short.
	always @(posedge ref_clk)
	begin
		cyc_cnt++;
		if (vector_fetch === 1'b1)
			vf_cnt++;
		if (cyc_cnt == 90000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic check_rng(input string what, input int v, input int lo, input int hi);
		check(what, v, (v >= lo && v <= hi) ? v : lo);
	endtask

	// One classic Wishbone cycle, held until ack is sampled high.
	task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do
			@(posedge ref_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		wb_xfer(1'b0, a, 8'h00);
		check(what, rd, {24'h000000, exp});
	endtask

	// Waits for internal reset, then counts its length and the cycles the pin is driven.
	task automatic run_seq(output int drv, output int len);
		len = 0;
		while (internal_reset !== 1'b1 && len < 50)
		begin
			@(posedge ref_clk);
			len++;
		end
		drv = (reset_pin_oe_n === 1'b0);
		len = 0;
		while (vector_fetch !== 1'b1 && len < 6000)
		begin
			@(posedge ref_clk);
			len++;
			if (reset_pin_oe_n === 1'b0)
				drv++;
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence of tests.
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		check("internal_reset", internal_reset, 1'b1);
		check("osc", osc_enable, 1'b1);
		check("cpu clk", cpu_clock_enable, 1'b0);
		check("pin out", reset_pin_out, 1'b0);
		check("gpio idle", gpio_pin_level, 1'b1);
		run_seq(drive, total);
		check_rng("por len", total, 4161, 4165);
		check("por drive", drive, 0);
		rd_chk(OFS_STATUS, STATUS_RST, "status por");
		rd_chk(8'h20, 8'h00, "unmapped reg");
		$display("test power-on done");
		pull_low <= 1'b1;
		repeat (30) @(posedge ref_clk);
		check("gpio", gpio_pin_level, 1'b0);
		check("pin off", internal_reset, 1'b0);
		pull_low <= 1'b0;
		wb_xfer(1'b1, OFS_CFG_TWO, 8'h01);
		repeat (10) @(posedge ref_clk);
		n = vf_cnt;
		pull_low <= 1'b1;
		repeat (5) @(posedge ref_clk);
		pull_low <= 1'b0;
		repeat (30) @(posedge ref_clk);
		check("short pin", vf_cnt, n);
		pull_low <= 1'b1;
		repeat (30) @(posedge ref_clk);
		check("pin halt", internal_reset, 1'b1);
		pull_low <= 1'b0;
		run_seq(drive, total);
		check("pin drive", drive, 0);
		rd_chk(OFS_STATUS, 8'h01 << FLAG_PIN, "status pin");
		rd_chk(OFS_CFG_TWO, 8'h01, "pin enable kept");
		$display("test pin reset done");
		n = vf_cnt;
		cpu_addr_unmapped <= 1'b1;
		repeat (8) @(posedge ref_clk);
		cpu_addr_unmapped <= 1'b0;
		repeat (5) @(posedge ref_clk);
		check("data unmapped", vf_cnt, n);
		for (int k = 0; k < 3; k++)
		begin
			n = resets_seen;
			cpu_illegal_opcode <= (k == 0);
			cpu_stop_instr <= (k == 1);
			cpu_opcode_fetch <= (k == 2);
			cpu_addr_unmapped <= (k == 2);
			@(posedge ref_clk);
			{cpu_illegal_opcode, cpu_stop_instr, cpu_opcode_fetch, cpu_addr_unmapped} <= 4'h0;
			run_seq(drive, total);
			check("drive", drive, 32);
			check_rng("internal_reset len", total, 66, 68);
			check("ext reset", resets_seen, n + 1);
			rd_chk(OFS_STATUS, 8'h01 << flag[k], "status cpu");
		end
		$display("test cpu resets done");
		n = vf_cnt;
		for (int k = 0; k < 6; k++)
		begin
			repeat (3000) @(posedge ref_clk);
			wb_xfer(1'b1, OFS_WDOG_SVC, 8'h5a);
		end
		check("serviced", vf_cnt, n);
		n = 0;
		while (internal_reset !== 1'b1 && n < 17000)
		begin
			@(posedge ref_clk);
			n++;
		end
		check_rng("wdog time", n, 16360, 16400);
		run_seq(drive, total);
		check("wdog drive", drive, 32);
		rd_chk(OFS_STATUS, 8'h01 << FLAG_WATCHDOG, "status wdog");
		$display("test watchdog done");
		wb_xfer(1'b1, OFS_BRK_AUX, 8'h01 << BRK_WDOG_DISABLE);
		n = vf_cnt;
		break_active <= 1'b1;
		monitor_mode <= 1'b1;
		repeat (18000) @(posedge ref_clk);
		check("break", vf_cnt, n);
		break_active <= 1'b0;
		monitor_mode <= 1'b0;
		$display("test break done");
		brownout_trip <= 1'b1;
		repeat (10) @(posedge ref_clk);
		brownout_trip <= 1'b0;
		run_seq(drive, total);
		check_rng("lvi len", total, 4163, 4172);
		check_rng("lvi drive", drive, 4128, 4136);
		rd_chk(OFS_STATUS, 8'h01 << FLAG_BROWNOUT, "status lvi");
		$display("test brownout done");
		// A power-on pulse restarts the long sequence and clears the pin enable.
		power_on_pulse <= 1'b1;
		repeat (10) @(posedge ref_clk);
		power_on_pulse <= 1'b0;
		run_seq(drive, total);
		check_rng("pwr len", total, 4163, 4172);
		check("pwr drive", drive, 0);
		rd_chk(OFS_STATUS, STATUS_RST, "status pwr");
		rd_chk(OFS_CFG_TWO, CFG_TWO_RST, "pin enable cleared");
		n = 0;
		repeat (40)
		begin
			@(posedge ref_clk);
			if (bus_clock_en === 1'b1)
				n++;
		end
		check("bus clk", n, 10);
		$display("test power-on pulse done");
		// Stop with stop enabled, then wake with short and then long recovery.
		for (int k = 0; k < 2; k++)
		begin
			total = vf_cnt;
			wb_xfer(1'b1, OFS_CFG_ONE, (8'h01 << CFG1_STOP_ENABLE)
				| ((k == 0) ? (8'h01 << CFG1_SHORT_STOP) : 8'h00));
			cpu_stop_instr <= 1'b1;
			@(posedge ref_clk);
			cpu_stop_instr <= 1'b0;
			n = 0;
			repeat (8)
			begin
				@(posedge ref_clk);
				if (bus_clock_en === 1'b1)
					n++;
			end
			check("stop bus clk", n, 0);
			check("stop cpu clk", cpu_clock_enable, 1'b0);
			check("stop osc", osc_enable, 1'b0);
			check("stop internal_reset", internal_reset, 1'b0);
			wake_event <= 1'b1;
			@(posedge ref_clk);
			wake_event <= 1'b0;
			n = 0;
			while (cpu_clock_enable !== 1'b1 && n < 5000)
			begin
				@(posedge ref_clk);
				n++;
			end
			check_rng("wake len", n, (k == 0) ? 32 : 4096, (k == 0) ? 34 : 4098);
			check("stop no reset", vf_cnt, total);
		end
		$display("test stop recovery done");
		end_of_test();
	end
endmodule

// file: hw/reset_seq_pkg.sv
// Purpose: Shared constants for the reset source sequencer.
// Assumes: One 125 MHz clock, which is the fast oscillator clock.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package reset_seq_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CFG_ONE = 8'h04;
	localparam logic [7:0] OFS_CFG_TWO = 8'h08;
	localparam logic [7:0] OFS_BRK_AUX = 8'h0c;
	localparam logic [7:0] OFS_WDOG_SVC = 8'h10;

	// Reset status flag positions.
	localparam int FLAG_POWER_ON = 7;
	localparam int FLAG_PIN = 6;
	localparam int FLAG_WATCHDOG = 5;
	localparam int FLAG_BAD_OPCODE = 4;
	localparam int FLAG_BAD_ADDRESS = 3;
	localparam int FLAG_BROWNOUT = 1;

	// Configuration field positions.
	localparam int CFG1_SHORT_STOP = 0;
	localparam int CFG1_STOP_ENABLE = 1;
	localparam int CFG2_PIN_ENABLE = 0;
	localparam int BRK_WDOG_DISABLE = 1;

	// Reset values.
	localparam logic [7:0] STATUS_RST = 8'h80;
	localparam logic [7:0] CFG_ONE_RST = 8'h00;
	localparam logic [7:0] CFG_TWO_RST = 8'h00;
	localparam logic [7:0] BRK_AUX_RST = 8'h00;

	// Sequence phase lengths in fast oscillator cycles.
	localparam logic [11:0] POR_LAST = 12'hfff;
	localparam logic [11:0] DRIVE_LAST = 12'h01f;
	localparam logic [11:0] HOLD_LAST = 12'h01f;
	localparam logic [11:0] FINAL_LAST = 12'h002;
	localparam logic [11:0] STOP_SHORT_LAST = 12'h01f;
	localparam logic [11:0] STOP_LONG_LAST = 12'hfff;

	// Minimum low time of the reset pin, and its count of cycles rounded up.
	localparam int CLK_PERIOD_PS = 8000;
	localparam int PIN_LOW_MIN_NS = 100;
	localparam int PIN_LOW_CYCLES = (PIN_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Sequencer states, Gray coded along the reset path.
	typedef enum logic [2:0] {
		S_POR_WAIT = 3'b000,
		S_PIN_DRIVE = 3'b001,
		S_INTERNAL_RESET_HOLD = 3'b011,
		S_FINAL = 3'b010,
		S_RUN = 3'b110,
		S_STOP = 3'b111,
		S_STOP_WAKE = 3'b101,
		S_EXT_HOLD = 3'b100
	} seq_state_e;

endpackage

// file: hw/reset_source_sequencer.sv
// Purpose: Collects reset sources, sequences internal reset and the reset pin,
// records the cause and runs the shared prescaler and watchdog.
// Assumes: ref_clk is the fast oscillator clock; all cpu_* inputs share it.
// Notes: The prescaler advances on the rising edge of the single clock.
//
// Summary of operation
// - Every source asserts internal reset, then vector fetch.
// - Internal resets clear prescaler; pin reset does not.
// - Each cause sets its own status flag.
// - Qualified long pin low halts processing, flags pin.
// - Pin is plain input until pin enable set.
// - Internal sources drive pin low 32 cycles.
// - Internal reset holds 35 cycles after pin release (32 hold, 3 final).
// - Power-on/brownout count 4096; only brownout drives pin low first.
// - Recovery is 4163 or 67 cycles total.
// - Power-on prescaler counts 4096, release 67 later.
// - Power-on enables oscillator, stops CPU clocks, flags.
// - Watchdog overflow causes internal reset and flag.
// - Service write clears watchdog and prescaler bits 11:4.
// - Prescaler wrap clocks watchdog at least every 4096.
// - Break in monitor mode may disable watchdog.
// - Illegal instruction sets flag and resets.
// - Stop with stop disabled is an illegal opcode.
// - Only opcode fetch from unmapped address resets.
// - Brownout holds pin low, counts 4096 after recovery.
// - Twelve prescaler stages, wrap stage clocks watchdog.
// - Stop clears prescaler; wake waits 32 or 4096.
// - Prescaler free-runs after every reset.
`timescale 1ns/100ps

module reset_source_sequencer
	import reset_seq_pkg::*;
#(
	parameter int WDOG_WIDTH = 6
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic power_on_pulse,
	input wire logic brownout_trip,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	input wire logic cpu_illegal_opcode,
	input wire logic cpu_stop_instr,
	input wire logic cpu_opcode_fetch,
	input wire logic cpu_addr_unmapped,
	input wire logic break_active,
	input wire logic monitor_mode,
	input wire logic wake_event,
	output logic internal_reset,
	output logic vector_fetch,
	output logic osc_enable,
	output logic cpu_clock_enable,
	output logic bus_clock_en,
	output logic gpio_pin_level
);

	// Refuse watchdog widths that the counter cannot serve.
	if (WDOG_WIDTH < 2 || WDOG_WIDTH > 16)
	begin : g_bad_width
		$error("WDOG_WIDTH must lie between 2 and 16.");
	end

	logic [2:0] sy1_q, sy2_q, sy3_q, flt_q, flt_d;
	seq_state_e st_q, st_d;
	logic [11:0] presc_q, presc_d, stay_q, stay_d;
	logic [WDOG_WIDTH-1:0] wdog_q, wdog_d;
	logic [7:0] pinlow_q, pinlow_d;
	logic [7:0] status_q, status_d, cfg1_q, cfg1_d, cfg2_q, cfg2_d, brk_q, brk_d;
	logic [1:0] div_q, div_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic internal_reset_q, internal_reset_d, oe_n_q, oe_n_d, vec_q, vec_d, osc_q, osc_d;
	logic cpuen_q, cpuen_d, busen_q, busen_d, gpio_q, gpio_d;
	logic por_lvl, bo_lvl, pin_low, pin_hit, presc_wrap, wdog_tick, wdog_ovf, brk_dis;
	logic bus_wr, svc_wr, stop_bad;
	logic [7:0] int_cause;

	// Pin and power inputs pass three flip-flops; a change counts when the last two agree.
	always_comb
	begin
		flt_d = flt_q;
		for (int i = 0; i < 3; i++)
		begin
			if (sy2_q[i] == sy3_q[i])
			begin
				flt_d[i] = sy3_q[i];
			end
		end
	end

	// Synchroniser registers; bit 0 power-on, bit 1 brownout, bit 2 reset pin.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			sy1_q <= 3'h4;
			sy2_q <= 3'h4;
			sy3_q <= 3'h4;
			flt_q <= 3'h4;
		end
		else
		begin
			sy1_q <= {reset_pin_in, brownout_trip, power_on_pulse};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			flt_q <= flt_d;
		end
	end

	// Source decode shared by the sequencer and its checks.
	assign por_lvl = flt_q[0];
	assign bo_lvl = flt_q[1];
	assign pin_low = ~flt_q[2] & cfg2_q[CFG2_PIN_ENABLE];
	assign pin_hit = pin_low && (pinlow_q >= 8'(PIN_LOW_CYCLES - 1));
	assign presc_wrap = (presc_q == POR_LAST);
	assign brk_dis = break_active & monitor_mode & brk_q[BRK_WDOG_DISABLE];
	assign wdog_tick = presc_wrap && (st_q == S_RUN) && !brk_dis;
	assign wdog_ovf = wdog_tick && (&wdog_q);
	assign stop_bad = cpu_stop_instr && !cfg1_q[CFG1_STOP_ENABLE];
	assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
	assign svc_wr = bus_wr && (wb_adr_i == OFS_WDOG_SVC);

	// Next-state logic for the bus slave, registers, prescaler and sequencer.
	always_comb
	begin
		st_d = st_q;
		presc_d = presc_q + 12'h001;
		wdog_d = wdog_q;
		status_d = status_q;
		cfg1_d = cfg1_q;
		cfg2_d = cfg2_q;
		brk_d = brk_q;
		vec_d = 1'b0;
		int_cause = 8'h00;
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		rdat_d = 32'h0000_0000;
		pinlow_d = 8'h00;
		div_d = div_q + 2'h1;

		// Bus reads answer with the register in the low byte; unmapped reads give zero.
		if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q)
		begin
			case (wb_adr_i)
				OFS_STATUS: rdat_d[7:0] = status_q;
				OFS_CFG_ONE: rdat_d[7:0] = cfg1_q;
				OFS_CFG_TWO: rdat_d[7:0] = cfg2_q;
				OFS_BRK_AUX: rdat_d[7:0] = brk_q;
				default: rdat_d = 32'h0000_0000;
			endcase
		end

		// Bus writes; status flags clear by writing one, hardware sets below win.
		if (bus_wr)
		begin
			case (wb_adr_i)
				OFS_STATUS: status_d = status_q & ~wb_dat_i[7:0];
				OFS_CFG_ONE: cfg1_d = wb_dat_i[7:0];
				OFS_CFG_TWO: cfg2_d = wb_dat_i[7:0];
				OFS_BRK_AUX: brk_d = wb_dat_i[7:0];
				default: cfg1_d = cfg1_q;
			endcase
		end

		// Watchdog service clears the watchdog and the upper prescaler stages.
		if (svc_wr)
		begin
			wdog_d = '0;
			presc_d[11:4] = 8'h00;
		end
		else if (wdog_tick)
		begin
			wdog_d = wdog_q + 1'b1;
		end

		// Pin low time is measured only while the pin is not driven by this block.
		if (pin_low && (st_q == S_RUN || st_q == S_STOP || st_q == S_STOP_WAKE))
		begin
			pinlow_d = (pinlow_q == 8'hff) ? pinlow_q : pinlow_q + 8'h01;
		end

		// Reset sources in priority order, then the phase sequence.
		if (por_lvl)
		begin
			st_d = S_POR_WAIT;
			presc_d = 12'h000;
			status_d = 8'h00;
			status_d[FLAG_POWER_ON] = 1'b1;
			cfg2_d = CFG_TWO_RST;
			cfg1_d = CFG_ONE_RST;
			brk_d = BRK_AUX_RST;
			wdog_d = '0;
		end
		else if (bo_lvl)
		begin
			st_d = S_POR_WAIT;
			presc_d = 12'h000;
			status_d = (st_q == S_POR_WAIT) ? status_q : 8'h00;
			status_d[FLAG_BROWNOUT] = 1'b1;
			cfg1_d = CFG_ONE_RST;
			brk_d = BRK_AUX_RST;
			wdog_d = '0;
		end
		else
		begin
			case (st_q)
				S_POR_WAIT:
				begin
					if (presc_q == POR_LAST)
					begin
						st_d = S_PIN_DRIVE;
					end
				end
				S_PIN_DRIVE:
				begin
					if (stay_q == DRIVE_LAST)
					begin
						st_d = S_INTERNAL_RESET_HOLD;
					end
				end
				S_INTERNAL_RESET_HOLD:
				begin
					if (stay_q == HOLD_LAST)
					begin
						st_d = S_FINAL;
					end
				end
				S_FINAL:
				begin
					if (stay_q == FINAL_LAST)
					begin
						st_d = S_RUN;
						vec_d = 1'b1;
					end
				end
				S_EXT_HOLD:
				begin
					if (!pin_low)
					begin
						st_d = S_INTERNAL_RESET_HOLD;
					end
				end
				S_RUN:
				begin
					if (pin_hit)
					begin
						int_cause[FLAG_PIN] = 1'b1;
					end
					else if (wdog_ovf)
					begin
						int_cause[FLAG_WATCHDOG] = 1'b1;
					end
					else if (cpu_illegal_opcode || stop_bad)
					begin
						int_cause[FLAG_BAD_OPCODE] = 1'b1;
					end
					else if (cpu_opcode_fetch && cpu_addr_unmapped)
					begin
						int_cause[FLAG_BAD_ADDRESS] = 1'b1;
					end
					else if (cpu_stop_instr)
					begin
						st_d = S_STOP;
						presc_d = 12'h000;
					end
				end
				S_STOP:
				begin
					presc_d = 12'h000;
					if (pin_hit)
					begin
						int_cause[FLAG_PIN] = 1'b1;
					end
					else if (wake_event)
					begin
						st_d = S_STOP_WAKE;
					end
				end
				S_STOP_WAKE:
				begin
					if (pin_hit)
					begin
						int_cause[FLAG_PIN] = 1'b1;
					end
					else if (stay_q == (cfg1_q[CFG1_SHORT_STOP] ? STOP_SHORT_LAST
						: STOP_LONG_LAST))
					begin
						st_d = S_RUN;
					end
				end
				default: st_d = S_POR_WAIT;
			endcase

			// A new reset replaces the recorded cause and restores default settings except the pin enable.
			if (int_cause != 8'h00)
			begin
				status_d = int_cause;
				cfg1_d = CFG_ONE_RST;
				brk_d = BRK_AUX_RST;
				wdog_d = '0;
				if (int_cause[FLAG_PIN])
				begin
					st_d = S_EXT_HOLD;
				end
				else
				begin
					st_d = S_PIN_DRIVE;
					presc_d = 12'h000;
				end
			end
		end

		// Registered outputs follow the next state.
		stay_d = (st_d != st_q) ? 12'h000 : stay_q + 12'h001;
		internal_reset_d = !(st_d == S_RUN || st_d == S_STOP || st_d == S_STOP_WAKE);
		oe_n_d = !(cfg2_d[CFG2_PIN_ENABLE] && (st_d == S_POR_WAIT || st_d == S_PIN_DRIVE));
		cpuen_d = !(st_d == S_POR_WAIT || st_d == S_STOP || st_d == S_STOP_WAKE);
		osc_d = (st_d != S_STOP);
		busen_d = (div_d == 2'h0) && cpuen_d;
		gpio_d = flt_d[2];
	end

	// State registers.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			st_q <= S_POR_WAIT;
			presc_q <= 12'h000;
			stay_q <= 12'h000;
			wdog_q <= '0;
			pinlow_q <= 8'h00;
			status_q <= STATUS_RST;
			cfg1_q <= CFG_ONE_RST;
			cfg2_q <= CFG_TWO_RST;
			brk_q <= BRK_AUX_RST;
			div_q <= 2'h0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
			internal_reset_q <= 1'b1;
			oe_n_q <= 1'b1;
			vec_q <= 1'b0;
			osc_q <= 1'b1;
			cpuen_q <= 1'b0;
			busen_q <= 1'b0;
			gpio_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			presc_q <= presc_d;
			stay_q <= stay_d;
			wdog_q <= wdog_d;
			pinlow_q <= pinlow_d;
			status_q <= status_d;
			cfg1_q <= cfg1_d;
			cfg2_q <= cfg2_d;
			brk_q <= brk_d;
			div_q <= div_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			internal_reset_q <= internal_reset_d;
			oe_n_q <= oe_n_d;
			vec_q <= vec_d;
			osc_q <= osc_d;
			cpuen_q <= cpuen_d;
			busen_q <= busen_d;
			gpio_q <= gpio_d;
		end
	end

	// Outputs come straight from flip-flops, except reset_pin_out, which is tied low; the pin only ever pulls low.
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_n = oe_n_q;
	assign internal_reset = internal_reset_q;
	assign vector_fetch = vec_q;
	assign osc_enable = osc_q;
	assign cpu_clock_enable = cpuen_q;
	assign bus_clock_en = busen_q;
	assign gpio_pin_level = gpio_q;

	// Helper: cycles since the last prescaler wrap or service.
	logic [12:0] gap_q;
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || presc_wrap || svc_wr || st_q != S_RUN)
		begin
			gap_q <= 13'h0000;
		end
		else
		begin
			gap_q <= gap_q + 13'h0001;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	property p_drive_len;
		(st_q == S_PIN_DRIVE && st_d == S_INTERNAL_RESET_HOLD) |-> stay_q == 12'h01f;
	endproperty
	a_drive_len: assert property (p_drive_len) else $error("pin drive not 32 cycles");

	property p_hold_len;
		(st_q == S_INTERNAL_RESET_HOLD && st_d == S_FINAL) |-> stay_q == 12'h01f && reset_pin_oe_n;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("reset hold not 32 cycles");

	property p_final_len;
		(st_q == S_FINAL && st_d == S_RUN) |=> vector_fetch && !internal_reset && $past(stay_q) == 12'h002;
	endproperty
	a_final_len: assert property (p_final_len) else $error("final phase wrong");

	property p_por_count;
		(st_q == S_POR_WAIT && st_d == S_PIN_DRIVE) |-> presc_q == 12'hfff && !cpu_clock_enable;
	endproperty
	a_por_count: assert property (p_por_count) else $error("power-on count not 4096");

	property p_internal_reset_held;
		(st_q != S_RUN && st_q != S_STOP && st_q != S_STOP_WAKE) |-> internal_reset;
	endproperty
	a_internal_reset_held: assert property (p_internal_reset_held) else $error("internal reset dropped early");

	property p_wdog_reset;
		(wdog_ovf && st_q == S_RUN && !por_lvl && !bo_lvl && !pin_hit)
			|=> st_q == S_PIN_DRIVE && status_q[FLAG_WATCHDOG] ##1 !reset_pin_oe_n || !cfg2_q[0];
	endproperty
	a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog overflow ignored");

	property p_service;
		svc_wr && !por_lvl && !bo_lvl |=> presc_q[11:4] == 8'h00 && wdog_q == '0;
	endproperty
	a_service: assert property (p_service) else $error("service did not clear");

	property p_wrap_gap;
		st_q == S_RUN |-> gap_q <= 13'h0fff;
	endproperty
	a_wrap_gap: assert property (p_wrap_gap) else $error("prescaler wrap too late");

	property p_stop_bad;
		(st_q == S_RUN && stop_bad && !cpu_illegal_opcode && !pin_hit && !wdog_ovf && !por_lvl && !bo_lvl)
			|=> status_q == 8'h10 && st_q == S_PIN_DRIVE;
	endproperty
	a_stop_bad: assert property (p_stop_bad) else $error("disabled stop not illegal");

	property p_data_unmapped;
		(st_q == S_RUN && cpu_addr_unmapped && !cpu_opcode_fetch && !cpu_illegal_opcode && !cpu_stop_instr
			&& !pin_hit && !wdog_ovf && !por_lvl && !bo_lvl) |=> st_q == S_RUN;
	endproperty
	a_data_unmapped: assert property (p_data_unmapped) else $error("data access reset");

	property p_pin_keeps_presc;
		(st_q == S_RUN && st_d == S_EXT_HOLD && !svc_wr) |=> presc_q == $past(presc_q) + 12'h001;
	endproperty
	a_pin_keeps_presc: assert property (p_pin_keeps_presc) else $error("pin reset cleared prescaler");

	property p_wake_len;
		(st_q == S_STOP_WAKE && st_d == S_RUN)
			|-> stay_q == (cfg1_q[CFG1_SHORT_STOP] ? 12'h01f : 12'hfff);
	endproperty
	a_wake_len: assert property (p_wake_len) else $error("stop recovery length wrong");

	c_por_done: cover property (st_q == S_FINAL && st_d == S_RUN && status_q[FLAG_POWER_ON]);
	c_wdog: cover property (st_q == S_RUN && st_d == S_PIN_DRIVE && wdog_ovf);
	c_wake: cover property (st_q == S_STOP_WAKE && st_d == S_RUN);
	c_pin: cover property (st_q == S_EXT_HOLD && st_d == S_INTERNAL_RESET_HOLD);

endmodule
